// ### logic/smbid_pkg.sv
`default_nettype none
package smbid_pkg;

  // Register offsets in the SMBus byte space
  localparam logic [7:0] OFS_ID = 8'h05;
  localparam logic [7:0] OFS_DEV = 8'h06;
  localparam logic [7:0] OFS_COUNT = 8'h07;
  localparam logic [7:0] OFS_SPARE = 8'h08;

  // Reset values and fixed fields
  localparam logic [4:0] COUNT_RST = 5'h08;
  localparam logic [2:0] COUNT_PAD = 3'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [6:0] BUS_ADDR = 7'h3B; // Arbitrary value

  // Bit counter limits
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_NONE = 4'h0;

  // Synchronised view of the two bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } smbid_line_s;

  // Bus engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_HACK = 3'b100
  } smbid_state_e;

  // Which byte of a write phase is being received
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD = 2'b01,
    PH_DATA = 2'b10
  } smbid_phase_e;

endpackage
`default_nettype wire

// ### logic/smbid_regs.sv
// Contract
// - Upper ID nibble is read-only revision code
// - Lower ID nibble is fixed vendor code
// - Next byte is read-only eight-bit device code
// - Byte count holds five writable bits
// - Count resets to eight; range zero to thirty-one
// - Byte after count reads all zero
// - Block read sends count, then bytes from offset
`timescale 1ns/1ps
`default_nettype none
module smbid_regs
  import smbid_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = BUS_ADDR,
  parameter logic [3:0] REV_CODE = 4'h3,     // Arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h5,  // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // SMBus pins, sda open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Configured block read length
  output logic [4:0] read_count_o
);

  smbid_line_s meta_ff, sync_ff, prev_ff;
  smbid_state_e st_ff, nxt_st;
  smbid_phase_e phase_ff, nxt_phase;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [4:0] count_ff, nxt_count;
  logic rd_ff, nxt_rd;
  logic first_ff, nxt_first;
  logic hack_ff, nxt_hack;
  logic sda_ff, nxt_sda;
  logic oe_ff, nxt_oe;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic tx_load, cnt_wr;
  logic [7:0] load_val, reg_val;

  // Two-flop synchronisers plus one history stage for edges
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '1;
      sync_ff <= '1;
      prev_ff <= '1;
    end else begin
      meta_ff <= '{scl: scl_i, sda: sda_i};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Line events
  assign scl_rise = sync_ff.scl && !prev_ff.scl;
  assign scl_fall = !sync_ff.scl && prev_ff.scl;
  assign start_c = sync_ff.scl && prev_ff.scl && prev_ff.sda && !sync_ff.sda;
  assign stop_c = sync_ff.scl && prev_ff.scl && !prev_ff.sda && sync_ff.sda;

  // Read view of the register bytes
  always_comb begin
    unique case (ptr_ff)
      OFS_ID: reg_val = {REV_CODE, VENDOR_CODE};
      OFS_DEV: reg_val = DEVICE_CODE;
      OFS_COUNT: reg_val = {COUNT_PAD, count_ff};
      OFS_SPARE: reg_val = ZERO_BYTE;
      default: reg_val = ZERO_BYTE;
    endcase
  end

  // First byte of a block read is the count, then the addressed bytes
  assign load_val = first_ff ? {COUNT_PAD, count_ff} : reg_val;

  // Bus engine next state
  always_comb begin
    nxt_st = st_ff;
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_count = count_ff;
    nxt_rd = rd_ff;
    nxt_first = first_ff;
    nxt_hack = hack_ff;
    nxt_sda = sda_ff;
    nxt_oe = oe_ff;
    tx_load = 1'b0;
    cnt_wr = 1'b0;
    if (start_c) begin
      // Start or repeated start always restarts address reception
      nxt_st = ST_RX;
      nxt_phase = PH_ADDR;
      nxt_cnt = BIT_NONE;
      nxt_oe = 1'b0;
      nxt_sda = 1'b1;
    end else if (stop_c) begin
      nxt_st = ST_IDLE;
      nxt_oe = 1'b0;
      nxt_sda = 1'b1;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && cnt_ff != BITS_BYTE) begin
            nxt_shift = {shift_ff[6:0], sync_ff.sda};
            nxt_cnt = cnt_ff + BIT_FIRST;
          end else if (scl_fall && cnt_ff == BITS_BYTE) begin
            nxt_cnt = BIT_NONE;
            nxt_st = ST_ACK;
            nxt_sda = 1'b0;
            nxt_oe = 1'b1;
            unique case (phase_ff)
              PH_ADDR: begin
                nxt_rd = shift_ff[0];
                nxt_first = 1'b1;
                if (shift_ff[7:1] != SLAVE_ADDR) begin
                  nxt_st = ST_IDLE;
                  nxt_sda = 1'b1;
                  nxt_oe = 1'b0;
                end
              end
              PH_CMD: nxt_ptr = shift_ff;
              default: begin
                // Only the count byte takes writes; ID bytes stay fixed
                if (ptr_ff == OFS_COUNT) begin
                  cnt_wr = 1'b1;
                  nxt_count = shift_ff[4:0];
                end
                nxt_ptr = ptr_ff + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (phase_ff == PH_ADDR && rd_ff) begin
              tx_load = 1'b1;
            end else begin
              nxt_oe = 1'b0;
              nxt_sda = 1'b1;
              nxt_st = ST_RX;
              nxt_phase = (phase_ff == PH_ADDR) ? PH_CMD : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == BITS_BYTE) begin
              nxt_oe = 1'b0;
              nxt_sda = 1'b1;
              nxt_st = ST_HACK;
            end else begin
              nxt_sda = shift_ff[7];
              nxt_oe = !shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + BIT_FIRST;
            end
          end
        end
        ST_HACK: begin
          if (scl_rise) begin
            nxt_hack = sync_ff.sda;
          end else if (scl_fall) begin
            if (hack_ff) begin
              nxt_st = ST_IDLE;
            end else begin
              tx_load = 1'b1;
            end
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
      // Put the next read byte's top bit on the line
      if (tx_load) begin
        nxt_st = ST_TX;
        nxt_sda = load_val[7];
        nxt_oe = !load_val[7];
        nxt_shift = {load_val[6:0], 1'b0};
        nxt_cnt = BIT_FIRST;
        nxt_first = 1'b0;
        if (!first_ff) begin
          nxt_ptr = ptr_ff + 8'h01;
        end
      end
    end
  end

  // Bus engine registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      phase_ff <= PH_ADDR;
      cnt_ff <= BIT_NONE;
      shift_ff <= ZERO_BYTE;
      ptr_ff <= ZERO_BYTE;
      count_ff <= COUNT_RST;
      rd_ff <= 1'b0;
      first_ff <= 1'b0;
      hack_ff <= 1'b1;
      sda_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      count_ff <= nxt_count;
      rd_ff <= nxt_rd;
      first_ff <= nxt_first;
      hack_ff <= nxt_hack;
      sda_ff <= nxt_sda;
      oe_ff <= nxt_oe;
    end
  end

  // Outputs straight from flops
  assign sda_o = sda_ff;
  assign sda_oe_o = oe_ff;
  assign read_count_o = count_ff;

  // Helper: set once the count byte has ever been written
  logic wrote_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wrote_ff <= 1'b0;
    end else begin
      wrote_ff <= wrote_ff || cnt_wr;
    end
  end

  property p_rev_code;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_load && !first_ff && ptr_ff == OFS_ID |=> {sda_o, shift_ff[7:5]} == REV_CODE;
  endproperty
  a_rev_code: assert property (p_rev_code) else $error("revision nibble wrong");

  property p_vendor_code;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_load && !first_ff && ptr_ff == OFS_ID |=> shift_ff[4:1] == VENDOR_CODE;
  endproperty
  a_vendor_code: assert property (p_vendor_code) else $error("vendor nibble wrong");

  property p_dev_code;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_load && !first_ff && ptr_ff == OFS_DEV |=> {sda_o, shift_ff[7:1]} == DEVICE_CODE;
  endproperty
  a_dev_code: assert property (p_dev_code) else $error("device code wrong");

  property p_count_write;
    @(posedge ref_clk_i) disable iff (rst_i)
      st_ff == ST_RX && phase_ff == PH_DATA && ptr_ff == OFS_COUNT && scl_fall
      && cnt_ff == BITS_BYTE |=> read_count_o == $past(shift_ff[4:0]) ##1 st_ff == ST_ACK;
  endproperty
  a_count_write: assert property (p_count_write) else $error("count not written");

  property p_count_reset;
    @(posedge ref_clk_i) disable iff (rst_i)
      !wrote_ff |-> read_count_o == COUNT_RST;
  endproperty
  a_count_reset: assert property (p_count_reset) else $error("count default lost");

  property p_spare_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_load && !first_ff && ptr_ff == OFS_SPARE |=> !sda_oe_o == 1'b0 && shift_ff == ZERO_BYTE;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare byte not zero");

  property p_count_pad;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_load && !first_ff && ptr_ff == OFS_COUNT |=> sda_oe_o && shift_ff[7:6] == 2'b00;
  endproperty
  a_count_pad: assert property (p_count_pad) else $error("count pad not zero");

  property p_count_first;
    @(posedge ref_clk_i) disable iff (rst_i) tx_load && first_ff |=>
      sda_oe_o && !first_ff && shift_ff[5:1] == count_ff && $stable(ptr_ff);
  endproperty
  a_count_first: assert property (p_count_first) else $error("count not sent first");

  // Main scenarios
  c_block_read: cover property (@(posedge ref_clk_i) disable iff (rst_i) tx_load && first_ff);
  c_count_write: cover property (@(posedge ref_clk_i) disable iff (rst_i) cnt_wr);
  c_host_nack: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff == ST_HACK && scl_fall && hack_ff);

endmodule
`default_nettype wire

// ### sim/smbid_host.sv
`timescale 1ns/1ps
`default_nettype none
module smbid_host
  import smbid_pkg::*;
(
  // Clock and resolved data line
  input wire logic clk_i,
  input wire logic sda_i,
  // Host pins, sda 1 releases the line
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Pins change only just after falling edges
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Start or repeated start, sda falls while scl high
  task automatic start();
    sda_o = 1'b1;
    wt(4);
    scl_o = 1'b1;
    wt(8);
    sda_o = 1'b0;
    wt(8);
    scl_o = 1'b0;
  endtask
  // Stop, sda rises while scl high
  task automatic stop();
    wt(2);
    sda_o = 1'b0;
    wt(4);
    scl_o = 1'b1;
    wt(8);
    sda_o = 1'b1;
    wt(8);
  endtask
  // Eight bits and the ack slot, MSB first; line sampled mid-high
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      wt(2);
      sda_o = d[i];
      wt(6);
      scl_o = 1'b1;
      wt(4);
      r[i] = sda_i;
      wt(4);
      scl_o = 1'b0;
    end
  endtask
  // Offset write phase, repeated start, then read address
  task automatic read_from(input logic [7:0] ofs);
    logic [8:0] r;
    start();
    xfer({BUS_ADDR, 1'b0, 1'b1}, r);
    xfer({ofs, 1'b1}, r);
    start();
    xfer({BUS_ADDR, 1'b1, 1'b1}, r);
  endtask
endmodule
`default_nettype wire

// ### sim/tb_smbus_id_bytecount_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_smbus_id_bytecount_regs
  import smbid_pkg::*;
;
  localparam logic [3:0] REV = 4'h3;   // Arbitrary value
  localparam logic [3:0] VEN = 4'h5;   // Arbitrary value
  localparam logic [7:0] DEV = 8'hA6;  // Arbitrary value
  logic ref_clk_i, rst_i, scl, host_sda, sda_o, sda_oe_o, line;
  logic [4:0] read_count_o;
  logic [8:0] r;
  int error_cnt, n_compared, cyc;
  // Written value beside the count it should leave
  logic [12:0] rows [5] = '{{8'h03, 5'h03}, {8'hE5, 5'h05}, {8'hE0, 5'h00},
    {8'h1F, 5'h1F}, {8'h08, 5'h08}};
  // Open-drain line with pull-up
  assign line = host_sda & ~(sda_oe_o & ~sda_o);
  smbid_regs #(.REV_CODE(REV), .VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .read_count_o(read_count_o));
  smbid_host host (.clk_i(ref_clk_i), .sda_i(line), .scl_o(scl), .sda_o(host_sda));
  // Clock source
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [4:0] got, input logic [4:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected byte at an offset
  function automatic logic [7:0] expb(input logic [7:0] ofs, input logic [4:0] cnt);
    case (ofs)
      OFS_ID: expb = {REV, VEN};
      OFS_DEV: expb = DEV;
      OFS_COUNT: expb = {3'h0, cnt};
      default: expb = ZERO_BYTE;
    endcase
  endfunction
  // Write one byte at an offset, checking the data byte ack
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    host.start();
    host.xfer({BUS_ADDR, 1'b0, 1'b1}, r);
    host.xfer({ofs, 1'b1}, r);
    host.xfer({v, 1'b1}, r);
    chk_byte({7'h0, r[0]}, 8'h00);
    host.stop();
  endtask
  // Block read of n bytes after the count byte
  task automatic blk(input logic [7:0] ofs, input int n, input logic [4:0] cnt);
    host.read_from(ofs);
    host.xfer({8'hFF, 1'b0}, r);
    chk_byte(r[8:1], {3'h0, cnt});
    for (int i = 0; i < n; i++) begin
      host.xfer({8'hFF, i == n - 1}, r);
      chk_byte(r[8:1], expb(ofs + 8'(i), cnt));
    end
    host.stop();
  endtask
  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    rst_i = 1'b1;
    host.wt(5);
    rst_i = 1'b0;
    host.wt(4);
    chk_cnt(read_count_o, COUNT_RST);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_COUNT, rows[i][12:5]);
      chk_cnt(read_count_o, rows[i][4:0]);
      blk(OFS_ID, 4, rows[i][4:0]);
      $display("Row %0d done", i);
    end
    // Writes to read-only and spare bytes change nothing
    wr(OFS_ID, 8'hFF);
    wr(OFS_DEV, 8'h00);
    wr(OFS_SPARE, 8'hFF);
    blk(OFS_ID, 4, 5'h08);
    $display("Read-only writes done");
    // Block reads from later offsets, the one from the count byte running past the mapped bytes
    blk(OFS_DEV, 3, 5'h08);
    blk(OFS_COUNT, 3, 5'h08);
    $display("Offset read done");
    // Foreign address gets no ack
    host.start();
    host.xfer({7'h2A, 1'b0, 1'b1}, r);
    chk_byte({7'h0, r[0]}, 8'h01);
    host.stop();
    $display("Foreign address done");
    // Reset in mid-transfer restores the count
    wr(OFS_COUNT, 8'h02);
    host.start();
    host.xfer({BUS_ADDR, 1'b0, 1'b1}, r);
    rst_i = 1'b1;
    host.wt(5);
    chk_cnt(read_count_o, COUNT_RST);
    rst_i = 1'b0;
    host.stop();
    blk(OFS_ID, 4, COUNT_RST);
    $display("Reset test done");
    final_report();
  end
endmodule
`default_nettype wire
